// ### logic/serial_flash_cmd_decoder.sv
// Summary of operation
// R1 - opcode 06h sets write permit latch
// R2 - opcode 04h clears write permit latch
// R3 - decode pause, continue, burst length, otp enter/leave
// R4 - opcode B9h enters deep sleep
// R5 - 00h no effect; 66h arms, 99h resets
// R6 - reset only when arm came directly before
// R7 - 9Fh returns maker byte then two id bytes
// R8 - status, config, config2, discovery register opcodes
// R9 - invalid sequence: output released until next select
// R10 - sample rising, drive falling; dtr uses both
// R11 - otp mode blocks main array access
// R12 - first byte is opcode, msb first
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

module serial_flash_cmd_decoder #(
  parameter logic [7:0] MAKER_ID = 8'h5c,  // arbitrary value
  parameter logic [7:0] DEV_ID_A = 8'h31,  // arbitrary value
  parameter logic [7:0] DEV_ID_B = 8'h27   // arbitrary value
) (
  input  wire logic        clk_i,                 // 10 MHz system clock
  input  wire logic        rst_i,                 // async reset, active high
  input  wire logic        cs_n_i,                // chip select pin, active low
  input  wire logic        sclk_i,                // serial clock pin
  input  wire logic        sdi_i,                 // serial data in pin
  input  wire logic        dtr_mode_i,            // double transfer rate select
  input  wire logic [7:0]  disc_data_i,           // discovery byte at disc_addr_o
  output logic             sdo_o,                 // serial data out
  output logic             sdo_oe_o,              // high while sdo_o is driven
  output logic             write_permit_latch_o,  // write permit latch
  output logic             pause_pulse_o,         // suspend program/erase, pulse
  output logic             continue_pulse_o,      // resume program/erase, pulse
  output logic             deep_sleep_o,          // deep power down active
  output logic [7:0]       burst_len_o,           // burst length setting
  output logic             otp_area_o,            // secured area only, array blocked
  output logic             mem_reset_o,           // memory reset, pulse
  output logic [7:0]       status_o,              // status byte
  output logic [7:0]       config_o,              // configuration byte
  output logic [7:0]       config2_o,             // second configuration byte
  output logic [23:0]      disc_addr_o            // discovery read address
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  spi_sample_if smp ();

  spi_pin_sampler u_sampler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cs_n_i (cs_n_i),
    .sclk_i (sclk_i),
    .sdi_i  (sdi_i),
    .smp    (smp.producer)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  flash_cmd_pkg::frame_state_t st_q;
  flash_cmd_pkg::frame_state_t st_d;
  logic [2:0]  bit_q;
  logic [6:0]  rx_q;
  logic [7:0]  op_q;
  logic [2:0]  cnt_q;
  logic [31:0] addr_q;
  logic [7:0]  d0_q;
  logic [7:0]  d1_q;
  logic        armed_q;
  logic        reset_ok_q;
  logic [7:0]  tx_q;
  logic [2:0]  tx_bit_q;
  logic [1:0]  id_idx_q;

  // ----------------------------------------------------------------
  // edge selection and receive decode
  // ----------------------------------------------------------------
  wire       rx_ev   = smp.sclk_rise | (dtr_mode_i & smp.sclk_fall);  // R10
  wire       tx_ev   = smp.sclk_fall | (dtr_mode_i & smp.sclk_rise);  // R10
  wire [7:0] rx_byte = {rx_q, smp.sdi};                               // R12
  wire       in_frame = smp.cs_low & ~smp.cs_fall;
  wire       byte_done = in_frame & rx_ev & (bit_q == 3'h7);
  wire [2:0] cnt_inc = cnt_q + 3'h1;

  // opcode lookup on the byte just completed
  wire op_single = (rx_byte == `OP_NO_OPERATION) | (rx_byte == `OP_WRITE_PERMIT)
                 | (rx_byte == `OP_WRITE_FORBID) | (rx_byte == `OP_PROG_ERASE_PAUSE)
                 | (rx_byte == `OP_PROG_ERASE_CONTINUE) | (rx_byte == `OP_DEEP_SLEEP)
                 | (rx_byte == `OP_OTP_AREA_ENTER) | (rx_byte == `OP_OTP_AREA_LEAVE)
                 | (rx_byte == `OP_RESET_ARM) | (rx_byte == `OP_MEMORY_RESET);
  wire op_din    = (rx_byte == `OP_BURST_LENGTH) | (rx_byte == `OP_STATUS_CONFIG_WRITE);
  wire op_dout   = (rx_byte == `OP_IDENT_READ) | (rx_byte == `OP_STATUS_READ)
                 | (rx_byte == `OP_CONFIG_READ);
  wire op_addr   = (rx_byte == `OP_DISCOVERY_READ) | (rx_byte == `OP_CONFIG2_READ)
                 | (rx_byte == `OP_CONFIG2_WRITE);
  wire op_wake   = (rx_byte == `OP_RESET_ARM) | (rx_byte == `OP_MEMORY_RESET);
  wire op_ok     = deep_sleep_o ? op_wake : (op_single | op_din | op_dout | op_addr);

  // byte counts of the current command
  wire [2:0] addr_need = (op_q == `OP_DISCOVERY_READ) ? `DISCOVERY_ADDR_BYTES
                                                      : `CONFIG2_ADDR_BYTES;
  wire [2:0] din_max   = (op_q == `OP_STATUS_CONFIG_WRITE) ? `STATUS_WRITE_MAX_BYTES
                                                           : `ONE_DATA_BYTE;
  wire       addr_then_write = (op_q == `OP_CONFIG2_WRITE);

  // command executes at the frame end on a byte boundary
  wire exec = smp.cs_rise & (bit_q == 3'h0)
            & ((st_q == flash_cmd_pkg::ST_DONE)
            | ((st_q == flash_cmd_pkg::ST_DIN) & (cnt_q != 3'h0)));

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      flash_cmd_pkg::ST_IDLE, flash_cmd_pkg::ST_STANDBY: begin
        st_d = st_q;                                                  // R9
      end
      flash_cmd_pkg::ST_OPCODE: begin
        if (byte_done) begin
          if (!op_ok) st_d = flash_cmd_pkg::ST_STANDBY;               // R9
          else if (op_single) st_d = flash_cmd_pkg::ST_DONE;
          else if (op_din) st_d = flash_cmd_pkg::ST_DIN;
          else if (op_dout) st_d = flash_cmd_pkg::ST_DOUT;
          else st_d = flash_cmd_pkg::ST_ADDR;
        end
      end
      flash_cmd_pkg::ST_ADDR: begin
        if (byte_done && cnt_inc == addr_need) begin
          st_d = addr_then_write ? flash_cmd_pkg::ST_DIN : flash_cmd_pkg::ST_DOUT;
        end
      end
      flash_cmd_pkg::ST_DIN: begin
        if (byte_done && cnt_inc == din_max) st_d = flash_cmd_pkg::ST_DONE;
      end
      flash_cmd_pkg::ST_DONE: begin
        if (byte_done) st_d = flash_cmd_pkg::ST_STANDBY;              // R9
      end
      flash_cmd_pkg::ST_DOUT: begin
        st_d = st_q;
      end
      default: st_d = flash_cmd_pkg::ST_IDLE;
    endcase
    if (smp.cs_fall) st_d = flash_cmd_pkg::ST_OPCODE;                 // R12
    else if (smp.cs_rise) st_d = flash_cmd_pkg::ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) st_q <= flash_cmd_pkg::ST_IDLE;
    else st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // receive shifter, byte counters and captured fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_q  <= 3'h0;
      rx_q   <= 7'h00;
      cnt_q  <= 3'h0;
      op_q   <= `OP_NO_OPERATION;
      addr_q <= 32'h0000_0000;
      d0_q   <= 8'h00;
      d1_q   <= 8'h00;
    end else if (smp.cs_fall) begin
      bit_q <= 3'h0;
      cnt_q <= 3'h0;
    end else if (in_frame && rx_ev && st_q != flash_cmd_pkg::ST_DOUT) begin
      bit_q <= bit_q + 3'h1;
      rx_q  <= rx_byte[6:0];                                          // R12
      if (byte_done) begin
        case (st_q)
          flash_cmd_pkg::ST_OPCODE: op_q <= rx_byte;
          flash_cmd_pkg::ST_ADDR: addr_q <= {addr_q[23:0], rx_byte};  // R8
          flash_cmd_pkg::ST_DIN: begin
            if (cnt_q == 3'h0) d0_q <= rx_byte;
            else d1_q <= rx_byte;
          end
          default: d0_q <= d0_q;
        endcase
        cnt_q <= (st_q == flash_cmd_pkg::ST_ADDR && cnt_inc == addr_need) ? 3'h0
               : ((st_q == flash_cmd_pkg::ST_OPCODE) ? cnt_q : cnt_inc);
      end
    end else if (st_q == flash_cmd_pkg::ST_DOUT && tx_ev && tx_bit_q == 3'h0
                 && op_q == `OP_DISCOVERY_READ) begin
      addr_q <= addr_q + 32'h1;                                       // R8
    end
  end

  // ----------------------------------------------------------------
  // reset arming, judged at each opcode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q    <= 1'b0;
      reset_ok_q <= 1'b0;
    end else if (byte_done && st_q == flash_cmd_pkg::ST_OPCODE) begin
      armed_q    <= (rx_byte == `OP_RESET_ARM);                        // R6
      reset_ok_q <= armed_q & (rx_byte == `OP_MEMORY_RESET);           // R5
    end
  end

  // ----------------------------------------------------------------
  // transmit path: next byte selection and falling-edge shifting, both edges in dtr mode
  // ----------------------------------------------------------------
  wire [7:0] id_byte = (id_idx_q == 2'h0) ? MAKER_ID
                     : ((id_idx_q == 2'h1) ? DEV_ID_A : DEV_ID_B);      // R7
  wire [7:0] next_tx = (op_q == `OP_STATUS_READ)  ? status_o
                     : (op_q == `OP_CONFIG_READ)  ? config_o
                     : (op_q == `OP_CONFIG2_READ) ? config2_o
                     : (op_q == `OP_IDENT_READ)   ? id_byte
                     : disc_data_i;                                   // R8
  wire       tx_go   = (st_q == flash_cmd_pkg::ST_DOUT) & smp.cs_low & tx_ev;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_o    <= 1'b0;
      tx_q     <= 8'h00;
      tx_bit_q <= 3'h0;
      id_idx_q <= 2'h0;
    end else if (st_q != flash_cmd_pkg::ST_DOUT) begin
      tx_bit_q <= 3'h0;
      id_idx_q <= 2'h0;
    end else if (tx_go) begin
      tx_bit_q <= tx_bit_q + 3'h1;
      if (tx_bit_q == 3'h0) begin
        sdo_o    <= next_tx[7];                                       // R10
        tx_q     <= {next_tx[6:0], 1'b0};
        id_idx_q <= (id_idx_q == `IDENT_BYTES - 2'h1) ? 2'h0 : id_idx_q + 2'h1;  // R7
      end else begin
        sdo_o <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // output driven only while answering; released in standby
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) sdo_oe_o <= 1'b0;
    else sdo_oe_o <= (st_d == flash_cmd_pkg::ST_DOUT);                // R9
  end

  // ----------------------------------------------------------------
  // command execution at the end of a well-formed frame
  // ----------------------------------------------------------------
  wire do_reset = exec & (op_q == `OP_MEMORY_RESET) & reset_ok_q;     // R6
  wire do_wr    = exec & write_permit_latch_o;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_permit_latch_o <= 1'b0;
      pause_pulse_o        <= 1'b0;
      continue_pulse_o     <= 1'b0;
      deep_sleep_o         <= 1'b0;
      burst_len_o          <= `BURST_LENGTH_RESET;
      otp_area_o           <= 1'b0;
      mem_reset_o          <= 1'b0;
      status_o             <= `STATUS_RESET;
      config_o             <= `CONFIG_RESET;
      config2_o            <= `CONFIG2_RESET;
    end else begin
      pause_pulse_o    <= exec & (op_q == `OP_PROG_ERASE_PAUSE);      // R3
      continue_pulse_o <= exec & (op_q == `OP_PROG_ERASE_CONTINUE);   // R3
      mem_reset_o      <= do_reset;                                   // R5
      if (do_reset) begin
        write_permit_latch_o <= 1'b0;
        deep_sleep_o         <= 1'b0;
        otp_area_o           <= 1'b0;
        burst_len_o          <= `BURST_LENGTH_RESET;
      end else if (exec) begin
        case (op_q)
          `OP_WRITE_PERMIT: write_permit_latch_o <= 1'b1;             // R1
          `OP_WRITE_FORBID: write_permit_latch_o <= 1'b0;             // R2
          `OP_DEEP_SLEEP: deep_sleep_o <= 1'b1;                       // R4
          `OP_BURST_LENGTH: burst_len_o <= d0_q;                      // R3
          `OP_OTP_AREA_ENTER: otp_area_o <= 1'b1;                     // R11
          `OP_OTP_AREA_LEAVE: otp_area_o <= 1'b0;                     // R11
          `OP_STATUS_CONFIG_WRITE: begin
            if (do_wr) begin
              status_o             <= d0_q;                           // R8
              config_o             <= (cnt_q == `STATUS_WRITE_MAX_BYTES) ? d1_q : config_o;
              write_permit_latch_o <= 1'b0;
            end
          end
          `OP_CONFIG2_WRITE: begin
            if (do_wr) begin
              config2_o            <= d0_q;                           // R8
              write_permit_latch_o <= 1'b0;
            end
          end
          default: deep_sleep_o <= deep_sleep_o;                      // R5
        endcase
      end
    end
  end

  assign disc_addr_o = addr_q[23:0];

endmodule : serial_flash_cmd_decoder

`default_nettype wire

// ### logic/flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// ----------------------------------------------------------------
// opcodes of the single-wire command set
// ----------------------------------------------------------------
`define OP_NO_OPERATION        8'h00
`define OP_WRITE_PERMIT        8'h06
`define OP_WRITE_FORBID        8'h04
`define OP_PROG_ERASE_PAUSE    8'hb0
`define OP_PROG_ERASE_CONTINUE 8'h30
`define OP_DEEP_SLEEP          8'hb9
`define OP_BURST_LENGTH        8'hc0
`define OP_OTP_AREA_ENTER      8'hb1
`define OP_OTP_AREA_LEAVE      8'hc1
`define OP_RESET_ARM           8'h66
`define OP_MEMORY_RESET        8'h99
`define OP_IDENT_READ          8'h9f
`define OP_DISCOVERY_READ      8'h5a
`define OP_STATUS_READ         8'h05
`define OP_CONFIG_READ         8'h15
`define OP_STATUS_CONFIG_WRITE 8'h01
`define OP_CONFIG2_READ        8'h71
`define OP_CONFIG2_WRITE       8'h72

// ----------------------------------------------------------------
// byte counts of the command frames
// ----------------------------------------------------------------
`define DISCOVERY_ADDR_BYTES   3'h3
`define CONFIG2_ADDR_BYTES     3'h4
`define STATUS_WRITE_MAX_BYTES 3'h2
`define ONE_DATA_BYTE          3'h1
`define IDENT_BYTES            2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STATUS_RESET           8'h00
`define CONFIG_RESET           8'h00
`define CONFIG2_RESET          8'h00
`define BURST_LENGTH_RESET     8'h00

`endif

// ### logic/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // command frame states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DIN,
    ST_DOUT,
    ST_DONE,
    ST_STANDBY
  } frame_state_t;

endpackage : flash_cmd_pkg

// ### logic/spi_sample_if.sv
`timescale 1ns/1ps
`default_nettype none

// sampled pin levels and edge events from the pin sampler
interface spi_sample_if;
  logic cs_low;     // chip select asserted, filtered level
  logic cs_fall;    // one-cycle pulse, frame starts
  logic cs_rise;    // one-cycle pulse, frame ends
  logic sclk_rise;  // one-cycle pulse
  logic sclk_fall;  // one-cycle pulse
  logic sdi;        // filtered serial input level

  modport producer (output cs_low, cs_fall, cs_rise, sclk_rise, sclk_fall, sdi);
  modport consumer (input cs_low, cs_fall, cs_rise, sclk_rise, sclk_fall, sdi);
endinterface : spi_sample_if

`default_nettype wire

// ### logic/spi_pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module spi_pin_sampler (
  input  wire logic     clk_i,    // system clock
  input  wire logic     rst_i,    // async reset, active high
  input  wire logic     cs_n_i,   // chip select pin, active low
  input  wire logic     sclk_i,   // serial clock pin
  input  wire logic     sdi_i,    // serial data in pin
  spi_sample_if.producer smp      // sampled levels and edges
);

  // ----------------------------------------------------------------
  // three-stage sampling, level moves when stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [2:0] pin_w;
  logic [2:0] lvl_d;
  logic [2:0] lvl_old_q;

  assign pin_w = {cs_n_i, sclk_i, sdi_i};

  // per-pin filter
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
    end
  endgenerate

  // synchroniser stages, idle levels: cs high, sclk low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q      <= 3'h4;
      s2_q      <= 3'h4;
      s3_q      <= 3'h4;
      lvl_q     <= 3'h4;
      lvl_old_q <= 3'h4;
    end else begin
      s1_q      <= pin_w;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      lvl_q     <= lvl_d;
      lvl_old_q <= lvl_q;
    end
  end

  // edge events from the filtered levels
  assign smp.cs_low    = ~lvl_q[2];
  assign smp.cs_fall   = lvl_old_q[2] & ~lvl_q[2];
  assign smp.cs_rise   = ~lvl_old_q[2] & lvl_q[2];
  assign smp.sclk_rise = ~lvl_old_q[1] & lvl_q[1];
  assign smp.sclk_fall = lvl_old_q[1] & ~lvl_q[1];
  assign smp.sdi       = lvl_q[0];

endmodule : spi_pin_sampler

`default_nettype wire

// ### testbench/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// serial host controller model
// ----------------------------------------------------------------
module flash_host_model (
  input  wire logic clk_i,  // system clock
  input  wire logic sdo_i,  // resolved serial data pin
  output var  logic cs_n_o, // chip select, active low
  output var  logic sclk_o, // serial clock, still outside frames
  output var  logic sdi_o   // serial data towards the device
);
  // idle pin levels from time zero
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  // one frame: nb bytes sent msb first, then nr bytes read back
  task automatic frame(input logic [47:0] tx, input int nb, input int nr, input logic dtr,
                       output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (i = 0; i < nb * 8; i++) begin
      repeat (2) @(posedge clk_i);
      sdi_o <= tx[47 - i];
      repeat (2) @(posedge clk_i);
      sclk_o <= ~sclk_o;
      if (!dtr) begin
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
    end
    // sampled late in the high phase since the device's pin sampler lags
    for (i = 0; i < nr * 8; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      sdi_o  <= ~sdi_o;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      rx = {rx[30:0], sdo_i};
      @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o; // released line shows no stale level
    repeat (8) @(posedge clk_i);
  endtask : frame
endmodule : flash_host_model

`default_nettype wire

// ### testbench/serial_flash_cmd_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none

module serial_flash_cmd_decoder_checker (
  input wire logic       clk_i,                // system clock
  input wire logic       rst_i,                // async reset
  input wire logic       cs_n_i,               // chip select pin
  input wire logic       sdo_oe_o,             // output enable
  input wire logic       write_permit_latch_o, // latch
  input wire logic       pause_pulse_o,        // pause pulse
  input wire logic       continue_pulse_o,     // continue pulse
  input wire logic       deep_sleep_o,         // deep sleep
  input wire logic       otp_area_o,           // secured area mode
  input wire logic       mem_reset_o,          // memory reset pulse
  input wire logic [7:0] burst_len_o,          // burst length
  input wire logic [7:0] status_o,             // status byte
  input wire logic [7:0] config_o,             // configuration byte
  input wire logic [7:0] config2_o             // second configuration byte
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  AST_OE_RELEASE: assert property ($rose(cs_n_i) |-> ##[1:8] !sdo_oe_o)
    else $error("output enable not dropped after deselect");
  AST_OE_IN_FRAME: assert property ($rose(sdo_oe_o) |-> !cs_n_i && !deep_sleep_o)
    else $error("output enabled outside a valid frame");

  // ----------------------------------------------------------------
  // command effects at frame end
  // ----------------------------------------------------------------
  AST_PAUSE_PULSE: assert property (pause_pulse_o |-> cs_n_i ##1 !pause_pulse_o)
    else $error("pause pulse malformed");
  AST_CONT_PULSE: assert property (continue_pulse_o |-> cs_n_i ##1 !continue_pulse_o)
    else $error("continue pulse malformed");
  AST_LATCH_AT_END: assert property ($changed(write_permit_latch_o) |-> cs_n_i)
    else $error("latch changed inside a frame");
  AST_WRITE_NEEDS_LATCH: assert property ($changed({status_o, config_o, config2_o})
    |-> $past(write_permit_latch_o) && cs_n_i)
    else $error("register written without latch");
  AST_RESET_CLEARS: assert property (mem_reset_o |=> !write_permit_latch_o && !deep_sleep_o
    && !otp_area_o && burst_len_o == 8'h00)
    else $error("memory reset left state behind");
  AST_SLEEP_EXIT: assert property ($fell(deep_sleep_o) |-> mem_reset_o || $past(mem_reset_o))
    else $error("deep sleep left without reset");
  AST_OTP_AT_END: assert property ($changed({otp_area_o, burst_len_o}) |-> cs_n_i)
    else $error("mode changed inside a frame");
endmodule : serial_flash_cmd_decoder_checker

bind serial_flash_cmd_decoder serial_flash_cmd_decoder_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
  .write_permit_latch_o(write_permit_latch_o), .pause_pulse_o(pause_pulse_o),
  .continue_pulse_o(continue_pulse_o), .deep_sleep_o(deep_sleep_o), .otp_area_o(otp_area_o),
  .mem_reset_o(mem_reset_o), .burst_len_o(burst_len_o), .status_o(status_o),
  .config_o(config_o), .config2_o(config2_o)
);

`default_nettype wire

// ### testbench/serial_flash_cmd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module serial_flash_cmd_decoder_tb;
  localparam logic [7:0] MK = 8'h5c; // arbitrary value
  localparam logic [7:0] IA = 8'h31; // arbitrary value
  localparam logic [7:0] IB = 8'h27; // arbitrary value
  logic        clk_i, rst_i, dtr_mode_i, cs_n, sclk, sdi, sdo, sdo_oe;
  logic        latch, pause, cont, sleep, otp, mrst;
  logic [7:0]  burst, status, cfg, cfg2, disc_data;
  logic [23:0] disc_addr;
  logic [31:0] rx;
  wire logic   sdo_pin;
  int          miscompares, compares, n_pause, n_cont, n_rst, n0;

  // ----------------------------------------------------------------
  // clock, pin resolution, discovery table, pulse counters
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  assign sdo_pin   = sdo_oe ? sdo : 1'bz;
  assign disc_data = disc_addr[7:0] ^ 8'ha5;
  always @(posedge clk_i) begin
    n_pause <= n_pause + int'(pause);
    n_cont  <= n_cont + int'(cont);
    n_rst   <= n_rst + int'(mrst);
  end

  flash_host_model host (.clk_i(clk_i), .sdo_i(sdo_pin), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));
  serial_flash_cmd_decoder #(.MAKER_ID(MK), .DEV_ID_A(IA), .DEV_ID_B(IB)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .dtr_mode_i(dtr_mode_i), .disc_data_i(disc_data), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .write_permit_latch_o(latch), .pause_pulse_o(pause), .continue_pulse_o(cont),
    .deep_sleep_o(sleep), .burst_len_o(burst), .otp_area_o(otp), .mem_reset_o(mrst),
    .status_o(status), .config_o(cfg), .config2_o(cfg2), .disc_addr_o(disc_addr));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cmd(input logic [47:0] tx, input int nb, input int nr);
    host.frame(tx << (8 * (6 - nb)), nb, nr, dtr_mode_i, rx);
  endtask : cmd

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_latch;
    cmd(48'h06, 1, 0);
    check("latch set", latch, 1'b1);
    cmd(48'h04, 1, 0);
    check("latch clear", latch, 1'b0);
    cmd(48'h0133, 2, 0);
    check("status unlatched", status, 8'h00);
    $display("test latch done");
  endtask : t_latch

  task automatic t_settings;
    n0 = n_pause;
    cmd(48'hb0, 1, 0);
    check("pause count", n_pause, n0 + 1);
    n0 = n_cont;
    cmd(48'h30, 1, 0);
    check("continue count", n_cont, n0 + 1);
    cmd(48'hc05e, 2, 0);
    check("burst", burst, 8'h5e);
    cmd(48'hb1, 1, 0);
    check("otp on", otp, 1'b1);
    cmd(48'hc1, 1, 0);
    check("otp off", otp, 1'b0);
    $display("test settings done");
  endtask : t_settings

  task automatic t_regs;
    cmd(48'h06, 1, 0);
    cmd(48'h01a53c, 3, 0);
    check("status", status, 8'ha5);
    check("config", cfg, 8'h3c);
    cmd(48'h06, 1, 0);
    cmd(48'h015a, 2, 0);
    check("status one byte", {status, cfg}, 16'h5a3c);
    cmd(48'h05, 1, 2);
    check("status read", rx[15:0], 16'h5a5a);
    cmd(48'h15, 1, 1);
    check("config read", rx[7:0], 8'h3c);
    cmd(48'h06, 1, 0);
    cmd(48'h7200000000c3, 6, 0);
    check("config2", cfg2, 8'hc3);
    cmd(48'h7100000000, 5, 2);
    check("config2 read", rx[15:0], 16'hc3c3);
    $display("test registers done");
  endtask : t_regs

  task automatic t_ident;
    cmd(48'h9f, 1, 4);
    check("ident", rx, {MK, IA, IB, MK});
    cmd(48'h5a0001fe, 4, 3);
    check("discovery", rx[23:0], 24'h5b5aa5);
    $display("test identification done");
  endtask : t_ident

  task automatic t_reset;
    cmd(48'hb1, 1, 0);
    cmd(48'hc077, 2, 0);
    cmd(48'h06, 1, 0);
    n0 = n_rst;
    cmd(48'h66, 1, 0);
    cmd(48'h00, 1, 0);
    cmd(48'h99, 1, 0);
    check("reset broken", n_rst, n0);
    check("nop latch", latch, 1'b1);
    cmd(48'hb9, 1, 0);
    check("sleep", sleep, 1'b1);
    cmd(48'h05, 1, 1);
    check("sleep read", rx[7:0], 8'hzz);
    cmd(48'h66, 1, 0);
    cmd(48'h99, 1, 0);
    check("reset count", n_rst, n0 + 1);
    check("reset state", {sleep, latch, otp, burst}, 11'h000);
    check("status kept", status, 8'h5a);
    $display("test reset done");
  endtask : t_reset

  task automatic t_invalid;
    cmd(48'hff, 1, 1);
    check("unknown read", rx[7:0], 8'hzz);
    cmd(48'h0600, 2, 0);
    check("extra byte", latch, 1'b0);
    cmd(48'h05, 1, 1);
    check("after standby", rx[7:0], 8'h5a);
    $display("test invalid done");
  endtask : t_invalid

  task automatic t_dtr;
    dtr_mode_i <= 1'b1;
    @(posedge clk_i);
    cmd(48'h06, 1, 0);
    check("dtr set", latch, 1'b1);
    cmd(48'h04, 1, 0);
    check("dtr clear", latch, 1'b0);
    @(posedge clk_i);
    dtr_mode_i <= 1'b0;
    $display("test dtr done");
  endtask : t_dtr

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_i      = 1'b1;
    dtr_mode_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_latch();
    t_settings();
    t_regs();
    t_ident();
    t_reset();
    t_invalid();
    t_dtr();
    final_report();
  end

  // cuts a hang short well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule : serial_flash_cmd_decoder_tb

`default_nettype wire
